// File: rmq_pkg.sv
// Purpose: shared constants for the result memory and query field block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: item and setting bit positions are shared with software

package rmq_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] RMQ_FIELD_MASK = 8'h00;
   localparam logic [7:0] RMQ_MEM_CTRL = 8'h04;
   localparam logic [7:0] RMQ_DEPTH = 8'h08;
   localparam logic [7:0] RMQ_COUNT = 8'h0c;
   localparam logic [7:0] RMQ_READ_START = 8'h10;
   localparam logic [7:0] RMQ_ITEM_DATA = 8'h14;
   localparam logic [7:0] RMQ_ITEM_INFO = 8'h18;
   localparam logic [7:0] RMQ_MON_VOLT = 8'h1c;
   localparam logic [7:0] RMQ_MON_CURR = 8'h20;
   localparam logic [7:0] RMQ_SETTINGS = 8'h24;
   localparam logic [7:0] RMQ_LIVE_DATA = 8'h28;
   localparam logic [7:0] RMQ_LIVE_INFO = 8'h2c;

   // ==========================================================
   // field layouts
   localparam int RMQ_MASK_W = 8;
   localparam int RMQ_PTR_W = 10;
   localparam int RMQ_DATA_W = 32;
   localparam int RMQ_FRAC_W = 4;
   localparam logic [7:0] RMQ_MASK_USED = 8'h7f;
   localparam int RMQ_CTRL_EN = 0;
   localparam int RMQ_CTRL_CLR = 1;
   localparam int RMQ_RS_ALL = 0;
   localparam int RMQ_SET_MON = 0;
   localparam int RMQ_SET_Q = 1;
   localparam int RMQ_SET_HDR = 2;
   localparam int RMQ_SET_RS232 = 3;
   localparam int RMQ_INFO_TERM = 8;
   localparam int RMQ_INFO_EOT = 9;
   localparam int RMQ_INFO_VALID = 10;
   localparam int RMQ_INFO_HDR = 11;

   // ==========================================================
   // reset values and limits
   localparam logic [7:0] RMQ_MASK_RST = 8'h14;
   localparam logic [9:0] RMQ_DEPTH_MIN = 10'h001;
   localparam logic [9:0] RMQ_DEPTH_MAX = 10'h3e8;
   localparam logic [9:0] RMQ_DEPTH_RST = 10'h3e8;

endpackage : rmq_pkg

// File: rmq_result_memory.sv
// Purpose: result field mask, result memory and query settings
// Assumes: measurement strobes come from logic on clk_i
// Notes: readout validity, separators and transfer ends are flagged per item
//    one register access at a time, ack one cycle after take
//    the item array has no reset; the count gates item data reads but not the item info fields
//    a store during a readout may move data under the cursor
//    depth or enable writes that change nothing leave memory intact
//    the link kind bit only changes how transfer ends are flagged
//    fields travel as a bit vector beside the result word
//    monitor values are passed through as they stand
//
// Summary of operation
// [RULE1] eight-bit field mask, values 0 to 255, chooses returned fields
// [RULE2] mask bits 0..6 are panel, dq judge, dq, c judge, c, bin, status
// [RULE3] memory keeps at most 1000 most recent results
// [RULE4] plain readout ends every item; all form uses commas, one end
// [RULE5] stored items carry the same fields as a live result
// [RULE6] on the bus link plain readout gives one item per receive
// [RULE7] on the serial link plain readout is one transfer
// [RULE8] clear empties memory; next result goes to first location
// [RULE9] count reads 0 to 1000 and never carries a header
// [RULE10] store one entry per measurement only while enabled
// [RULE11] changing the store enable empties the memory
// [RULE12] depth 1 to 1000, readable; changing it empties memory
// [RULE13] depth accepts fractions and rounds them away
// [RULE14] host uses external trigger before trusting the count
// [RULE15] monitor volts read first, then current
// [RULE16] monitor display switch shown in sub area, readable back
// [RULE17] second parameter selects dissipation or quality factor
// [RULE18] header flag says whether query answers carry a header
// [RULE19] a full memory overwrites its oldest entry

`timescale 1ns/100ps

module rmq_result_memory #(
   parameter int DEPTH_MAX = 1000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [rmq_pkg::RMQ_DATA_W-1:0] dat_i,
   output logic [rmq_pkg::RMQ_DATA_W-1:0] dat_o,
   output logic ack_o,
   // measurement side
   input wire logic meas_done_i,
   input wire logic [rmq_pkg::RMQ_DATA_W-1:0] meas_data_i,
   input wire logic [rmq_pkg::RMQ_DATA_W-1:0] mon_volt_i,
   input wire logic [rmq_pkg::RMQ_DATA_W-1:0] mon_curr_i,
   // settings to the instrument
   output logic mon_disp_o,
   output logic q_sel_o,
   output logic hdr_en_o
);
   import rmq_pkg::*;

   // ==========================================================
   // local limits
   // depth writes must clear the upper half-word, fraction aside
   localparam int DEPTH_TOP = 16;
   localparam logic [1:0] SEL_LOW_HALF = 2'h3;

   // ==========================================================
   // state
   typedef struct packed {
      logic [RMQ_MASK_W-1:0] mask;
      logic store_en;
      logic [RMQ_PTR_W-1:0] depth;
      logic [RMQ_PTR_W-1:0] wr;
      logic [RMQ_PTR_W-1:0] oldest;
      logic [RMQ_PTR_W-1:0] cnt;
      logic all_mode;
      logic [RMQ_PTR_W-1:0] cur;
      logic [RMQ_PTR_W-1:0] rem;
      logic mon_disp;
      logic q_sel;
      logic hdr;
      logic rs232;
      logic ack;
      logic [RMQ_DATA_W-1:0] dat;
      logic [RMQ_DATA_W-1:0] live;
      logic [RMQ_MASK_W-1:0] live_f;
   } rmq_state_t;

   rmq_state_t st;
   rmq_state_t next_st;

   // ==========================================================
   // item store
   // [RULE3] room for the most recent results
   logic [RMQ_DATA_W-1:0] mem_data [DEPTH_MAX];
   logic [RMQ_MASK_W-1:0] mem_fld [DEPTH_MAX];

   logic req;
   logic wr_req;
   logic rd_req;
   logic do_store;
   logic do_clear;
   logic [RMQ_PTR_W-1:0] store_at;
   logic [RMQ_MASK_W-1:0] fld_now;
   logic [RMQ_PTR_W:0] depth_rnd;
   logic [RMQ_DATA_W-1:0] info;

   function automatic logic [RMQ_PTR_W-1:0] rmq_wrap(
      input logic [RMQ_PTR_W-1:0] p,
      input logic [RMQ_PTR_W-1:0] d
   );
      if (p >= d - RMQ_DEPTH_MIN) begin
         return '0;
      end
      return p + RMQ_DEPTH_MIN;
   endfunction : rmq_wrap

   // ==========================================================
   // bus request
   assign req = cyc_i & stb_i & ~st.ack;
   assign wr_req = req & we_i;
   assign rd_req = req & ~we_i;
   // [RULE1] [RULE2] fields kept per mask, bit 7 unused
   assign fld_now = st.mask & RMQ_MASK_USED;
   // [RULE13] round fraction half up
   assign depth_rnd = {1'b0, dat_i[RMQ_FRAC_W +: RMQ_PTR_W]}
      + {{RMQ_PTR_W{1'b0}}, dat_i[RMQ_FRAC_W-1]};

   // ==========================================================
   // address decode
   logic hit_mask;
   logic hit_ctrl;
   logic hit_depth;
   logic hit_count;
   logic hit_start;
   logic hit_item;
   logic hit_info;
   logic hit_volt;
   logic hit_curr;
   logic hit_set;
   logic hit_live;
   logic hit_live_f;
   logic depth_ok;
   logic [RMQ_DATA_W-1:0] rd_word;

   assign hit_mask = (adr_i == RMQ_FIELD_MASK);
   assign hit_ctrl = (adr_i == RMQ_MEM_CTRL);
   assign hit_depth = (adr_i == RMQ_DEPTH);
   assign hit_count = (adr_i == RMQ_COUNT);
   assign hit_start = (adr_i == RMQ_READ_START);
   assign hit_item = (adr_i == RMQ_ITEM_DATA);
   assign hit_info = (adr_i == RMQ_ITEM_INFO);
   assign hit_volt = (adr_i == RMQ_MON_VOLT);
   assign hit_curr = (adr_i == RMQ_MON_CURR);
   assign hit_set = (adr_i == RMQ_SETTINGS);
   assign hit_live = (adr_i == RMQ_LIVE_DATA);
   assign hit_live_f = (adr_i == RMQ_LIVE_INFO);
   // [RULE12] only depths 1 to 1000 are taken
   assign depth_ok = (sel_i[1:0] == SEL_LOW_HALF)
      && (dat_i[RMQ_DATA_W-1:DEPTH_TOP] == '0)
      && (depth_rnd >= {1'b0, RMQ_DEPTH_MIN})
      && (depth_rnd <= {1'b0, RMQ_DEPTH_MAX});

   // ==========================================================
   // readout item info at cursor
   always_comb begin
      info = '0;
      info[RMQ_MASK_W-1:0] = mem_fld[st.cur];
      info[RMQ_INFO_VALID] = (st.rem != '0);
      // [RULE4] terminator after each plain item, only last for all
      info[RMQ_INFO_TERM] = ~st.all_mode | (st.rem == RMQ_DEPTH_MIN);
      // [RULE6] [RULE7] plain on bus link ends transfer per item
      info[RMQ_INFO_EOT] = (~st.all_mode & ~st.rs232)
         | (st.rem == RMQ_DEPTH_MIN);
      // [RULE18] header prefix on item answers when enabled
      info[RMQ_INFO_HDR] = st.hdr;
   end

   // ==========================================================
   // read data
   always_comb begin
      rd_word = '0;
      if (hit_mask) begin
         rd_word[RMQ_MASK_W-1:0] = st.mask;
      end else if (hit_ctrl) begin
         rd_word[RMQ_CTRL_EN] = st.store_en;
      end else if (hit_depth) begin
         rd_word[RMQ_PTR_W-1:0] = st.depth;
      end else if (hit_count) begin
         // [RULE9] plain count, no header bit
         rd_word[RMQ_PTR_W-1:0] = st.cnt;
      end else if (hit_start) begin
         rd_word[RMQ_RS_ALL] = st.all_mode;
      end else if (hit_item) begin
         // [RULE5] item in live result format, zero once drained
         if (st.rem != '0) begin
            rd_word = mem_data[st.cur];
         end
      end else if (hit_info) begin
         rd_word = info;
      end else if (hit_volt) begin
         // [RULE15] voltage read first
         rd_word = mon_volt_i;
      end else if (hit_curr) begin
         // [RULE15] current read second
         rd_word = mon_curr_i;
      end else if (hit_set) begin
         rd_word[RMQ_SET_MON] = st.mon_disp;
         rd_word[RMQ_SET_Q] = st.q_sel;
         rd_word[RMQ_SET_HDR] = st.hdr;
         rd_word[RMQ_SET_RS232] = st.rs232;
      end else if (hit_live) begin
         rd_word = st.live;
      end else if (hit_live_f) begin
         rd_word[RMQ_MASK_W-1:0] = st.live_f;
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      do_clear = 1'b0;
      next_st.ack = req;
      next_st.dat = '0;
      if (wr_req) begin
         if (hit_mask) begin
            // [RULE1] whole byte kept, reads back as written
            if (sel_i[0]) begin
               next_st.mask = dat_i[RMQ_MASK_W-1:0];
            end
         end else if (hit_ctrl) begin
            if (sel_i[0]) begin
               next_st.store_en = dat_i[RMQ_CTRL_EN];
               // [RULE11] enable change empties memory
               // [RULE8] clear command empties memory
               do_clear = dat_i[RMQ_CTRL_CLR]
                  | (dat_i[RMQ_CTRL_EN] != st.store_en);
            end
         end else if (hit_depth) begin
            // [RULE12] accept 1..1000, clear on change
            if (depth_ok) begin
               next_st.depth = depth_rnd[RMQ_PTR_W-1:0];
               do_clear = (depth_rnd[RMQ_PTR_W-1:0] != st.depth);
            end
         end else if (hit_start) begin
            if (sel_i[0]) begin
               next_st.all_mode = dat_i[RMQ_RS_ALL];
               next_st.cur = st.oldest;
               next_st.rem = st.cnt;
            end
         end else if (hit_set) begin
            if (sel_i[0]) begin
               // [RULE16] monitor display switch
               next_st.mon_disp = dat_i[RMQ_SET_MON];
               // [RULE17] d or q as second parameter
               next_st.q_sel = dat_i[RMQ_SET_Q];
               next_st.hdr = dat_i[RMQ_SET_HDR];
               next_st.rs232 = dat_i[RMQ_SET_RS232];
            end
         end
      end else if (rd_req) begin
         next_st.dat = rd_word;
         // data read moves the cursor on
         if (hit_item && st.rem != '0) begin
            next_st.cur = rmq_wrap(st.cur, st.depth);
            next_st.rem = st.rem - RMQ_DEPTH_MIN;
         end
      end
      // [RULE8] clear first, so a store lands at zero
      if (do_clear) begin
         next_st.wr = '0;
         next_st.oldest = '0;
         next_st.cnt = '0;
         next_st.rem = '0;
         next_st.cur = '0;
      end
      // [RULE10] store only while enabled after a clear takes effect
      do_store = meas_done_i & next_st.store_en;
      store_at = next_st.wr;
      // [RULE5] live copy keeps the fields a stored item gets
      if (meas_done_i) begin
         next_st.live = meas_data_i;
         next_st.live_f = fld_now;
      end
      if (do_store) begin
         next_st.wr = rmq_wrap(next_st.wr, next_st.depth);
         // [RULE19] full memory drops oldest
         if (next_st.cnt == next_st.depth) begin
            next_st.oldest = rmq_wrap(next_st.oldest, next_st.depth);
         end else begin
            next_st.cnt = next_st.cnt + RMQ_DEPTH_MIN;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.mask <= RMQ_MASK_RST;
         st.store_en <= 1'b0;
         // [RULE12] depth starts at its largest value
         st.depth <= RMQ_DEPTH_RST;
         st.wr <= '0;
         st.oldest <= '0;
         st.cnt <= '0;
         st.all_mode <= 1'b0;
         st.cur <= '0;
         st.rem <= '0;
         st.mon_disp <= 1'b0;
         st.q_sel <= 1'b0;
         st.hdr <= 1'b0;
         st.rs232 <= 1'b0;
         st.ack <= 1'b0;
         st.dat <= '0;
         st.live <= '0;
         st.live_f <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // memory write
   // [RULE10] one array write per stored result
   // no reset on the array; count gates item data reads, item info fields are read ungated
   always_ff @(posedge clk_i) begin
      if (!rst_i && do_store) begin
         mem_data[store_at] <= meas_data_i;
         mem_fld[store_at] <= fld_now;
      end
   end

   // ==========================================================
   // outputs
   assign dat_o = st.dat;
   assign ack_o = st.ack;
   assign mon_disp_o = st.mon_disp;
   assign q_sel_o = st.q_sel;
   assign hdr_en_o = st.hdr;

endmodule : rmq_result_memory

// File: rmq_chk_assertions.sv
// Purpose: bus and settings checks on the result memory block
// Assumes: classic wishbone master, one request at a time
// Notes: ports packed per line to fit; bound to every instance
`timescale 1ns/100ps
module rmq_chk
   import rmq_pkg::*;
#(parameter int DEPTH_MAX = 1000) (
   // bus side
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [RMQ_DATA_W-1:0] dat_i, dat_o,
   // settings outputs
   input wire logic mon_disp_o, q_sel_o, hdr_en_o
);
   // ==========================================
   // helpers
   wire logic tk = cyc_i && stb_i && !ack_o;
   wire logic rk = ack_o && !we_i;
   wire logic sw = tk && we_i && sel_i[0] && adr_i == RMQ_SETTINGS;
   wire logic [2:0] st = {hdr_en_o, q_sel_o, mon_disp_o};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_next; tk |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_cause; ack_o |-> $past(tk); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_unmap; rk && adr_i > RMQ_LIVE_INFO |-> dat_o == '0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_cnt; rk && adr_i == RMQ_COUNT |-> dat_o <= DEPTH_MAX; endproperty
   a_cnt: assert property (p_cnt) else $error("count high");
   property p_set_rd; rk && adr_i == RMQ_SETTINGS |-> dat_o[2:0] == st;
   endproperty
   a_set_rd: assert property (p_set_rd) else $error("readback");
   property p_set_wr; sw |=> st == $past(dat_i[2:0]); endproperty
   a_set_wr: assert property (p_set_wr) else $error("set write");
   property p_set_hold; !sw |=> $stable(st); endproperty
   // settings move only on a settings write
   a_set_hold: assert property (p_set_hold) else $error("set drift");
endmodule : rmq_chk
bind rmq_result_memory rmq_chk #(.DEPTH_MAX(DEPTH_MAX)) rmq_chk_i (.clk_i,
   .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .adr_i, .sel_i, .dat_i, .dat_o,
   .mon_disp_o, .q_sel_o, .hdr_en_o);

// File: rmq_meas_src.sv
// Purpose: measurement front end model
// Assumes: one go pulse per result
// Notes: data between strobes is inverted, never the held value
`timescale 1ns/100ps
module rmq_meas_src (
   // control
   input wire logic clk_i, rst_i, go_i,
   // results and monitors
   output logic done_o,
   output logic [31:0] data_o, volt_o, curr_o
);
   logic [31:0] val;
   always_ff @(posedge clk_i) begin
      done_o <= go_i && !rst_i;
      if (rst_i) val <= 32'hd000_0000;
      else if (done_o) val <= val + 32'h1;
   end
   assign data_o = done_o ? val : ~val;
   assign volt_o = 32'h0000_3bc5;
   assign curr_o = 32'h0000_0734;
endmodule : rmq_meas_src

// File: test_result_memory_and_query_fields.sv
// Purpose: register level tests of the result memory block
// Assumes: classic wishbone, ack one cycle after take
// Notes: item data index follows the model's result counter
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t got %h exp %h", $time, a, e); end end
module test_result_memory_and_query_fields;
   import rmq_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
   logic [7:0] adr_i = '0;
   logic [3:0] sel_i = '0;
   logic [31:0] dat_i = '0, dat_o, q, vol, cur, md;
   logic ack_o, done, mon_disp_o, q_sel_o, hdr_en_o;
   int fails = 0, cmp_count = 0, meas_n = 0;
   rmq_meas_src rmq_meas_src_i (.clk_i, .rst_i, .go_i(go), .done_o(done),
      .data_o(md), .volt_o(vol), .curr_o(cur));
   rmq_result_memory rmq_result_memory_i (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .meas_done_i(done),
      .meas_data_i(md), .mon_volt_i(vol), .mon_curr_i(cur), .mon_disp_o,
      .q_sel_o, .hdr_en_o);
   initial forever #10 clk_i = ~clk_i;
   // ==========================================
   // bus tasks
   task automatic final_report;
      $display("%0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
      adr_i <= a; dat_i <= d; sel_i <= 4'hf;
      // hold everything until ack is sampled
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      if (k >= 20) begin
         fails++;
         final_report();
      end
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd
   // results come only on the bench's go, an outside trigger
   task automatic meas;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
      meas_n++;
   endtask : meas
   // info first: a data read moves the cursor
   task automatic rdout(input logic a, s, input int n, f);
      logic l;
      wb(1'b1, RMQ_READ_START, {31'h0, a});
      for (int i = 0; i < n; i++) begin
         l = (i == n - 1);
         rd(RMQ_ITEM_INFO, {20'h0, 2'b01, ((a || s) ? l : 1'b1),
            (a ? l : 1'b1), 8'h7f});
         rd(RMQ_ITEM_DATA, 32'hd000_0000 + f + i);
      end
   endtask : rdout
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(RMQ_FIELD_MASK, 32'h14);
      rd(RMQ_DEPTH, 32'h3e8);
      rd(8'h30, 32'h0);
      wb(1'b1, RMQ_FIELD_MASK, 32'hff);
      rd(RMQ_FIELD_MASK, 32'hff);
      meas;
      rd(RMQ_LIVE_INFO, 32'h7f);
      rd(RMQ_COUNT, 32'h0);
      $display("test mask done");
      wb(1'b1, RMQ_DEPTH, 32'h28);
      rd(RMQ_DEPTH, 32'h3);
      wb(1'b1, RMQ_DEPTH, 32'h0);
      rd(RMQ_DEPTH, 32'h3);
      wb(1'b1, RMQ_MEM_CTRL, 32'h1);
      repeat (5) meas;
      rd(RMQ_COUNT, 32'h3);
      rdout(1'b0, 1'b0, 3, meas_n - 3);
      rdout(1'b1, 1'b0, 3, meas_n - 3);
      wb(1'b1, RMQ_SETTINGS, 32'h8);
      rdout(1'b0, 1'b1, 3, meas_n - 3);
      $display("test readout done");
      wb(1'b1, RMQ_MEM_CTRL, 32'h3);
      rd(RMQ_COUNT, 32'h0);
      meas;
      rdout(1'b1, 1'b1, 1, meas_n - 1);
      wb(1'b1, RMQ_MEM_CTRL, 32'h0);
      rd(RMQ_COUNT, 32'h0);
      meas;
      rd(RMQ_COUNT, 32'h0);
      wb(1'b1, RMQ_MEM_CTRL, 32'h1);
      meas;
      wb(1'b1, RMQ_DEPTH, 32'h3e80);
      rd(RMQ_COUNT, 32'h0);
      repeat (1002) meas;
      rd(RMQ_COUNT, 32'h3e8);
      $display("test memory done");
      rd(RMQ_MON_VOLT, 32'h0000_3bc5);
      rd(RMQ_MON_CURR, 32'h0000_0734);
      wb(1'b1, RMQ_SETTINGS, 32'h7);
      `CHK({hdr_en_o, q_sel_o, mon_disp_o}, 3'b111)
      rd(RMQ_SETTINGS, 32'h7);
      wb(1'b1, RMQ_SETTINGS, 32'h2);
      `CHK({hdr_en_o, q_sel_o, mon_disp_o}, 3'b010)
      $display("test settings done");
      final_report();
   end
endmodule : test_result_memory_and_query_fields
